// *** bbrc_regulator.v ***
// regulator control: mode gating, soft start, hysteretic boost, status
// Function
// - buck runs in normal, stop, restart; off in sleep and fail-safe.
// - pwm in normal and restart; pwm in stop only after an auto transition or via wake pin.
// - entering stop switches buck to asynchronous pfm.
// - pwm duty may reach full period for low input supply.
// - soft start at power-up, sleep-to-restart and fail-safe-to-restart.
// - start at minimum duty, held periods, then fixed steps upward.
// - at target output leave stepping and regulate normally in pwm.
// - status flags switch-node open, short and out-of-window output.
// - status flags never change mode or configuration.
// - boost allowed only while software enable bit is set.
// - one-bit select picks threshold and hysteresis; boost duty level is fixed.
// - boost starts below threshold, stops above threshold plus hysteresis.
// - active flag set on boost start; clear works only above threshold.
// - boost always fixed-frequency pwm, never pfm.
// - status flags boost pin open, short and lost ground.
// - peak overcurrent on shunt reduces boost duty.
// - clearing the auto bit disables the automatic stop-mode pfm-to-pwm change; wake-pin pwm still works.
`include "bbrc_defines.vh"
module bbrc_regulator #(
  parameter [7:0] SS_STEP = `BBRC_DUTY_STEP,
  parameter [7:0] SS_HOLD = `BBRC_HOLD_PER,
  parameter       TLAG_LONG_CYC  = `BBRC_TLAG_LONG_US * `BBRC_CLK_MHZ,
  parameter       TLAG_SHORT_CYC = `BBRC_TLAG_SHORT_US * `BBRC_CLK_MHZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq,
  input  wire [2:0]  sys_mode,
  input  wire        supply_below_th1,
  input  wire        supply_above_hys1,
  input  wire        supply_below_th2,
  input  wire        supply_above_hys2,
  input  wire        main_rail_at_target,
  input  wire        main_rail_out_window,
  input  wire        stepdown_switch_node_open,
  input  wire        stepdown_switch_node_short,
  input  wire        stepup_pin_open,
  input  wire        stepup_pin_short,
  input  wire        stepup_gnd_lost,
  input  wire        stepup_peak_oc,
  input  wire        stepdown_over_pfm_current,
  input  wire        wake_pin,
  input  wire [7:0]  stepdown_loop_duty,
  output reg         stepdown_enable,
  output reg         stepdown_pwm,
  output reg         stepdown_pwm_tick,
  output reg  [7:0]  stepdown_duty,
  output reg         stepdown_soft_start,
  output reg         stepup_enable,
  output reg  [7:0]  stepup_duty,
  output reg         stepup_pwm_tick
);
  localparam ST_OFF  = 3'b001;
  localparam ST_SOFT = 3'b010;
  localparam ST_RUN  = 3'b100;

  // two-flop synchronisers for all pin-side levels
  localparam NS = 15;
  wire [NS-1:0] raw = {stepdown_over_pfm_current, wake_pin, stepup_peak_oc, stepup_gnd_lost,
                       stepup_pin_short, stepup_pin_open, stepdown_switch_node_short,
                       stepdown_switch_node_open, main_rail_out_window, main_rail_at_target,
                       supply_above_hys2, supply_below_th2, supply_above_hys1,
                       supply_below_th1, 1'b0};
  reg [NS-1:0] sy1;
  reg [NS-1:0] sy;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1 <= {NS{1'b0}};
      sy  <= {NS{1'b0}};
    end else begin
      sy1 <= raw;
      sy  <= sy1;
    end
  end
  wire s_b1 = sy[1];
  wire s_h1 = sy[2];
  wire s_b2 = sy[3];
  wire s_h2 = sy[4];
  wire s_tgt = sy[5];
  wire s_win = sy[6];
  wire s_swo = sy[7];
  wire s_sws = sy[8];
  wire s_bo  = sy[9];
  wire s_bs  = sy[10];
  wire s_bg  = sy[11];
  wire s_oc  = sy[12];
  wire s_wk  = sy[13];
  wire s_pfm_over = sy[14];

  // control register; mode input is from on-chip logic, no sync
  reg [4:0] ctrl;
  reg [`BBRC_NFLAG-1:0] irq_stat;
  reg [`BBRC_NFLAG-1:0] irq_mask;
  reg stepup_active_flag;

  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr != `BBRC_A_CTRL) & (paddr != `BBRC_A_STAT) &
                   (paddr != `BBRC_A_IRQ_STAT) & (paddr != `BBRC_A_IRQ_MASK);

  wire mode_on = (sys_mode == `BBRC_MODE_NORMAL) | (sys_mode == `BBRC_MODE_STOP) |
                 (sys_mode == `BBRC_MODE_RESTART);
  wire in_stop = sys_mode == `BBRC_MODE_STOP;
  wire boost_v = ctrl[`BBRC_C_BOOST_V];
  // one selects first threshold, zero the second
  wire below_th = boost_v ? s_b1 : s_b2;
  wire above_off = boost_v ? s_h1 : s_h2;

  // fixed switching period shared by both converters
  reg [7:0] per_cnt;
  wire tick = per_cnt == `BBRC_PERIOD;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt <= 8'h00;
      stepdown_pwm_tick <= 1'b0;
      stepup_pwm_tick <= 1'b0;
    end else begin
      per_cnt <= tick ? 8'h00 : per_cnt + 8'h01;
      stepdown_pwm_tick <= tick & stepdown_pwm;
      stepup_pwm_tick <= tick & stepup_enable;
    end
  end

  // buck sequencing
  reg [2:0] state;
  reg [2:0] prev_mode;
  reg [7:0] hold_cnt;
  reg       started;
  reg       pwm_forced;
  reg [31:0] lag_cnt;
  wire lag_done = lag_cnt == 32'h0000_0000;
  wire [31:0] lag_load = ctrl[`BBRC_C_PWM_TLAG] ? TLAG_LONG_CYC : TLAG_SHORT_CYC;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_OFF;
      prev_mode <= `BBRC_MODE_SLEEP;
      hold_cnt <= 8'h00;
      started <= 1'b0;
      stepdown_duty <= 8'h00;
      pwm_forced <= 1'b0;
      lag_cnt <= 32'h0000_0000;
    end else begin
      prev_mode <= sys_mode;
      case (state)
        ST_OFF: begin
          stepdown_duty <= 8'h00;
          // power-up, sleep or fail-safe into restart
          if (mode_on) begin
            state <= ST_SOFT;
            stepdown_duty <= `BBRC_DUTY_MIN;
            hold_cnt <= 8'h00;
          end
        end
        ST_SOFT: begin
          if (!mode_on)
            state <= ST_OFF;
          else if (s_tgt)
            state <= ST_RUN;
          else if (tick) begin
            if (hold_cnt == SS_HOLD - 8'h01) begin
              hold_cnt <= 8'h00;
              if (stepdown_duty > `BBRC_DUTY_MAX - SS_STEP)
                stepdown_duty <= `BBRC_DUTY_MAX;
              else
                stepdown_duty <= stepdown_duty + SS_STEP;
            end else
              hold_cnt <= hold_cnt + 8'h01;
          end
        end
        ST_RUN: begin
          if (!mode_on)
            state <= ST_OFF;
          else
            stepdown_duty <= stepdown_loop_duty; // ff duty allowed
        end
        default: state <= ST_OFF;
      endcase
      // stop entry: back to pfm, arm transition lag
      if (in_stop && prev_mode != `BBRC_MODE_STOP) begin
        pwm_forced <= 1'b0;
        lag_cnt <= lag_load;
      end else if (!in_stop)
        pwm_forced <= 1'b0;
      else begin
        if (!lag_done)
          lag_cnt <= lag_cnt - 32'h0000_0001;
        // auto change only while auto bit set
        else if (ctrl[`BBRC_C_PWM_AUTO] && s_pfm_over)
          pwm_forced <= 1'b1;
      end
      started <= 1'b1;
    end
  end

  // pwm in normal/restart; in stop only via auto or wake pin
  wire stop_pwm = pwm_forced | (ctrl[`BBRC_C_PWM_BY_WK] & s_wk);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stepdown_enable <= 1'b0;
      stepdown_pwm <= 1'b0;
      stepdown_soft_start <= 1'b0;
    end else begin
      stepdown_enable <= mode_on & (state != ST_OFF);
      stepdown_pwm <= mode_on & (in_stop ? stop_pwm : 1'b1);
      stepdown_soft_start <= state == ST_SOFT;
    end
  end

  // hysteretic boost
  wire boost_allowed = ctrl[`BBRC_C_BOOST_EN] & mode_on &
                       (sys_mode != `BBRC_MODE_RESTART | ctrl[`BBRC_C_BOOST_EN]);
  reg boost_on;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_on <= 1'b0;
      stepup_enable <= 1'b0;
      stepup_duty <= 8'h00;
    end else begin
      if (!boost_allowed)
        boost_on <= 1'b0;
      else if (below_th)
        boost_on <= 1'b1;
      else if (above_off)
        boost_on <= 1'b0;
      // gate by allowed too, so a mode drop stops the switch at once
      stepup_enable <= boost_on & boost_allowed;
      // peak overcurrent cuts duty
      if (!boost_on)
        stepup_duty <= 8'h00;
      else if (s_oc)
        stepup_duty <= `BBRC_BST_NOM - `BBRC_OC_CUT;
      else
        stepup_duty <= `BBRC_BST_NOM;
    end
  end
  wire boost_start = boost_allowed & below_th & ~boost_on;

  // status: informational only; of the registers below, only ctrl feeds mode logic
  wire [`BBRC_NFLAG-1:0] live;
  assign live[`BBRC_S_SW_OPEN]  = s_swo;
  assign live[`BBRC_S_SW_SHORT] = s_sws;
  assign live[`BBRC_S_OUT_WIN]  = s_win;
  assign live[`BBRC_S_BST_OPEN] = s_bo;
  assign live[`BBRC_S_BST_SHORT] = s_bs;
  assign live[`BBRC_S_BST_GND]  = s_bg;
  assign live[`BBRC_S_STEPUP_ACTIVE_FLAG]  = boost_start;
  wire rd_irq = rd & (paddr == `BBRC_A_IRQ_STAT);
  wire wr_stat = wr & (paddr == `BBRC_A_STAT);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `BBRC_CTRL_RESET;
      irq_mask <= {`BBRC_NFLAG{1'b0}};
      irq_stat <= {`BBRC_NFLAG{1'b0}};
      stepup_active_flag <= 1'b0;
    end else begin
      if (wr && paddr == `BBRC_A_CTRL)
        ctrl <= pwdata[4:0];
      if (wr && paddr == `BBRC_A_IRQ_MASK)
        irq_mask <= pwdata[`BBRC_NFLAG-1:0];
      // read clears; a new event in the same cycle wins
      irq_stat <= (rd_irq ? {`BBRC_NFLAG{1'b0}} : irq_stat) | live;
      // set on start; write-one clear only above threshold
      if (boost_start)
        stepup_active_flag <= 1'b1;
      else if (wr_stat && pwdata[`BBRC_S_STEPUP_ACTIVE_FLAG] && !below_th)
        stepup_active_flag <= 1'b0;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `BBRC_A_CTRL:     prdata <= {27'h000_0000, ctrl};
        `BBRC_A_STAT:     prdata <= {25'h000_0000, stepup_active_flag, live[5:0]};
        `BBRC_A_IRQ_STAT: prdata <= {25'h000_0000, irq_stat};
        `BBRC_A_IRQ_MASK: prdata <= {25'h000_0000, irq_mask};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// *** bbrc_defines.vh ***
// constants for the buck/boost regulator control block
`ifndef BBRC_DEFINES_VH
`define BBRC_DEFINES_VH
`define BBRC_A_CTRL      8'h00
`define BBRC_A_STAT      8'h04
`define BBRC_A_IRQ_STAT  8'h08
`define BBRC_A_IRQ_MASK  8'h0C
`define BBRC_MODE_NORMAL  3'd0
`define BBRC_MODE_STOP    3'd1
`define BBRC_MODE_RESTART 3'd2
`define BBRC_MODE_SLEEP   3'd3
`define BBRC_MODE_FAILSAFE 3'd4
`define BBRC_C_BOOST_EN   0
`define BBRC_C_BOOST_V    1
`define BBRC_C_PWM_AUTO   2
`define BBRC_C_PWM_BY_WK  3
`define BBRC_C_PWM_TLAG   4
`define BBRC_CTRL_RESET   5'h04
`define BBRC_S_SW_OPEN    0
`define BBRC_S_SW_SHORT   1
`define BBRC_S_OUT_WIN    2
`define BBRC_S_BST_OPEN   3
`define BBRC_S_BST_SHORT  4
`define BBRC_S_BST_GND    5
`define BBRC_S_STEPUP_ACTIVE_FLAG    6
`define BBRC_NFLAG        7
`define BBRC_DUTY_W       8
`define BBRC_DUTY_MIN     8'h10
`define BBRC_DUTY_MAX     8'hFF
`define BBRC_DUTY_STEP    8'h10
`define BBRC_HOLD_PER     8'h04
`define BBRC_PERIOD       8'hDE
`define BBRC_OC_CUT       8'h20
`define BBRC_BST_NOM      8'h80
`define BBRC_TLAG_LONG_US 1000
`define BBRC_TLAG_SHORT_US 100
`define BBRC_CLK_MHZ      100
`endif

// *** bbrc_checker.sv ***
// port assertions for the regulator control block
`include "bbrc_defines.vh"
module bbrc_checker #(parameter [7:0] SS_STEP = 8'h10) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [2:0]  sys_mode,
  input wire        stepup_peak_oc,
  input wire        stepdown_enable,
  input wire        stepdown_pwm,
  input wire [7:0]  stepdown_duty,
  input wire        stepdown_soft_start,
  input wire        stepup_enable,
  input wire [7:0]  stepup_duty,
  input wire        stepup_pwm_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire off_md = sys_mode == `BBRC_MODE_SLEEP || sys_mode == `BBRC_MODE_FAILSAFE;
  wire pwm_md = sys_mode == `BBRC_MODE_NORMAL || sys_mode == `BBRC_MODE_RESTART;
  wire stop_md = sys_mode == `BBRC_MODE_STOP;
  // four samples: outputs are still low at the first edge after reset
  sequence s_run; !off_md [*4]; endsequence
  sequence s_off; off_md [*2]; endsequence
  sequence s_oc; stepup_peak_oc [*5] ##0 stepup_enable; endsequence
  a_buck_run_on: assert property (s_run |-> stepdown_enable)
    else $error("buck off in run mode");
  a_regs_off: assert property (s_off |-> !stepdown_enable && !stepup_enable)
    else $error("converter on in sleep or fail-safe");
  a_pwm_modes: assert property (pwm_md [*4] |-> stepdown_pwm)
    else $error("buck not pwm in normal or restart");
  a_stop_pfm: assert property (stop_md && !$past(stop_md) |=> !stepdown_pwm)
    else $error("buck not pfm on stop entry");
  a_ss_min: assert property ($rose(stepdown_soft_start) |-> stepdown_duty == `BBRC_DUTY_MIN)
    else $error("soft start not at minimum duty");
  a_ss_step: assert property (stepdown_soft_start && $past(stepdown_soft_start)
    && stepdown_duty != $past(stepdown_duty) && $past(stepdown_duty) < 8'hF0
    |-> stepdown_duty == $past(stepdown_duty) + SS_STEP) else $error("bad soft start step");
  a_oc_duty: assert property (s_oc |-> stepup_duty == `BBRC_BST_NOM - `BBRC_OC_CUT)
    else $error("boost duty not cut on overcurrent");
  a_tick_pulse: assert property (stepup_pwm_tick |=> !stepup_pwm_tick)
    else $error("boost tick not a pulse");
  a_unmapped: assert property (psel && penable && paddr > `BBRC_A_IRQ_MASK
    |-> pready && pslverr && (pwrite || prdata == 32'h0000_0000)) else $error("unmapped access");
endmodule
bind bbrc_regulator bbrc_checker #(.SS_STEP(SS_STEP)) bbrc_checker_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sys_mode, .stepup_peak_oc,
  .stepdown_enable, .stepdown_pwm, .stepdown_duty, .stepdown_soft_start, .stepup_enable,
  .stepup_duty, .stepup_pwm_tick);

// *** bbrc_plant.sv ***
// behavioural output rail: at target once duty at a pwm tick reaches TARGET
module bbrc_plant #(parameter [7:0] TARGET = 8'h40) (
  input wire        pclk,
  input wire        stepdown_enable,
  input wire        stepdown_pwm_tick,
  input wire [7:0]  stepdown_duty,
  output logic      main_rail_at_target
);
  timeunit 1ns;
  timeprecision 1ns;
  initial main_rail_at_target = 1'b0;
  // rail collapses when unpowered, so each restart must ramp again
  always @(posedge pclk) begin
    if (!stepdown_enable)
      main_rail_at_target <= 1'b0;
    else if (stepdown_pwm_tick && stepdown_duty >= TARGET)
      main_rail_at_target <= 1'b1;
  end
endmodule

// *** tb_bbrc_regulator.sv ***
// self-checking bench for the regulator control block
`include "bbrc_defines.vh"
module tb_bbrc_regulator;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, ld = 0, d;
  logic [31:0] pwdata = 0, rd, cv [3] = '{32'h0000_0004, 32'h0000_0000, 32'h0000_0008};
  logic [2:0]  sys_mode = `BBRC_MODE_NORMAL, md [2] = '{`BBRC_MODE_SLEEP, `BBRC_MODE_FAILSAFE};
  logic [3:0]  sup = 4'b1010;
  logic [5:0]  flt = 0;
  logic        oc = 0, poc = 0, wake = 0, err;
  wire  [31:0] prdata;
  wire  [7:0]  sd_duty, su_duty;
  wire         pready, pslverr, irq, sd_en, sd_pwm, sd_tick, sd_ss, su_en, su_tick, at_tgt;
  int          n_fail = 0, n_tests = 0, cycles = 0;
  bbrc_regulator #(.TLAG_LONG_CYC(20), .TLAG_SHORT_CYC(5)) bbrc_regulator_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .sys_mode,
    .supply_below_th1(sup[0]), .supply_above_hys1(sup[1]), .supply_below_th2(sup[2]),
    .supply_above_hys2(sup[3]), .main_rail_at_target(at_tgt), .main_rail_out_window(flt[2]),
    .stepdown_switch_node_open(flt[0]), .stepdown_switch_node_short(flt[1]),
    .stepup_pin_open(flt[3]), .stepup_pin_short(flt[4]), .stepup_gnd_lost(flt[5]),
    .stepup_peak_oc(oc), .stepdown_over_pfm_current(poc), .wake_pin(wake),
    .stepdown_loop_duty(ld), .stepdown_enable(sd_en), .stepdown_pwm(sd_pwm),
    .stepdown_pwm_tick(sd_tick), .stepdown_duty(sd_duty), .stepdown_soft_start(sd_ss),
    .stepup_enable(su_en), .stepup_duty(su_duty), .stepup_pwm_tick(su_tick));
  bbrc_plant bbrc_plant_i (.pclk, .stepdown_enable(sd_en), .stepdown_pwm_tick(sd_tick),
    .stepdown_duty(sd_duty), .main_rail_at_target(at_tgt));
  always #5 pclk = ~pclk;
  task conclude();
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      conclude();
    end
  end
  task chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // pready is sampled at every access edge until high, so wait states are tolerated
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd; end
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  initial begin
    void'($urandom(12));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, `BBRC_A_CTRL, 0);
    chk("ctrl", rd, 32'h0000_0004);
    apb(0, 8'h10, 0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    wait (sd_ss === 1);
    #1 chk("ss min", sd_duty, 8'h10);
    wait (sd_duty !== 8'h10);
    #1 chk("ss step", {sd_ss, sd_duty}, 9'h120);
    wait (sd_ss === 0);
    #1 chk("run pwm", sd_pwm, 1);
    for (int k = 0; k < 4; k++) begin
      d = k ? $urandom : 8'hFF;
      @(posedge pclk) ld <= d;
      cyc(230);
      chk("loop duty", sd_duty, d);
    end
    foreach (md[k]) begin
      @(posedge pclk) sys_mode <= md[k];
      cyc(4);
      chk("off", {sd_en, su_en}, 0);
      @(posedge pclk) sys_mode <= `BBRC_MODE_RESTART;
      cyc(4);
      chk("restart ss", {sd_en, sd_ss}, 2'b11);
      wait (sd_ss === 0);
      @(posedge pclk) sys_mode <= `BBRC_MODE_NORMAL;
    end
    for (int k = 0; k < 3; k++) begin
      apb(1, `BBRC_A_CTRL, cv[k]);
      @(posedge pclk) sys_mode <= `BBRC_MODE_STOP;
      cyc(3);
      chk("stop pfm", sd_pwm, 0);
      @(posedge pclk) begin poc <= 1; wake <= k[1]; end
      cyc(40);
      chk("stop pwm", sd_pwm, k != 1);
      @(posedge pclk) begin sys_mode <= `BBRC_MODE_NORMAL; poc <= 0; wake <= 0; end
      cyc(4);
    end
    apb(1, `BBRC_A_IRQ_MASK, 32'h0000_0040);
    @(posedge pclk) sup <= 4'b1001;
    cyc(8);
    chk("boost gated", su_en, 0);
    apb(1, `BBRC_A_CTRL, 32'h0000_0003);
    cyc(8);
    chk("boost on", {su_en, irq}, 2'b11);
    wait (su_tick === 1);
    #1 chk("bst tick", {su_tick, su_en}, 2'b11);
    apb(1, `BBRC_A_STAT, 32'h0000_0040);
    apb(0, `BBRC_A_STAT, 0);
    chk("act held", rd[6], 1);
    apb(0, `BBRC_A_IRQ_STAT, 0);
    chk("irq evt", rd[6], 1);
    apb(0, `BBRC_A_IRQ_STAT, 0);
    chk("irq clr", {rd[6], irq}, 0);
    @(posedge pclk) oc <= 1;
    cyc(8);
    chk("oc duty", su_duty, 8'h60);
    @(posedge pclk) oc <= 0;
    apb(1, `BBRC_A_CTRL, 32'h0000_0001);
    cyc(8);
    chk("th2 stop", su_en, 0);
    apb(1, `BBRC_A_STAT, 32'h0000_0040);
    apb(0, `BBRC_A_STAT, 0);
    chk("act clr", rd[6], 0);
    repeat (3) begin
      d = $urandom;
      @(posedge pclk) flt <= d[5:0];
      cyc(6);
      apb(0, `BBRC_A_STAT, 0);
      chk("flags", rd[5:0], d[5:0]);
      chk("mode kept", {sd_en, sd_pwm}, 2'b11);
    end
    conclude();
  end
endmodule
